// File: shared/sdrc_regs.svh
// Register offsets, field positions, reset values and codes of the block.
`ifndef SDRC_REGS_SVH
`define SDRC_REGS_SVH

// ======================================================================
// Offsets (byte addresses)
`define SDRC_OFS_CMD      8'h00
`define SDRC_OFS_BLK      8'h04
`define SDRC_OFS_STAT     8'h08
`define SDRC_OFS_MASK     8'h0C
`define SDRC_OFS_PROG     8'h10

// ======================================================================
// Command and transfer-mode fields
`define SDRC_CMD_RST      32'h00000000
`define SDRC_CMD_WMASK    32'h3FFB0033
`define SDRC_B_IDX_LO     24
`define SDRC_B_DP         21
`define SDRC_B_RESPONSE_INDEX_CHECK_ENABLE       20
`define SDRC_B_RESPONSE_CRC_CHECK_ENABLE       19
`define SDRC_B_FMT_LO     16
`define SDRC_B_MULTI_BLOCK_SELECT       5
`define SDRC_B_TRANSFER_DIRECTION       4
`define SDRC_B_BCE        1
`define SDRC_B_DE         0
`define SDRC_FMT_NONE     2'h0
`define SDRC_FMT_136      2'h1
`define SDRC_FMT_48       2'h2
`define SDRC_FMT_48B      2'h3
`define SDRC_AUTO_IDX     6'h0C

// ======================================================================
// Block register, status and mask
`define SDRC_BLK_RST      32'h00000000
`define SDRC_BLK_WMASK    32'hFFFF0FFF
`define SDRC_B_CNT_LO     16
`define SDRC_S_CDONE      0
`define SDRC_S_XDONE      1
`define SDRC_S_CRC        17
`define SDRC_S_IDX        19
`define SDRC_STAT_MASK    32'h000A0003

`endif

// File: shared/sdrc_pkg.sv
// Types shared by the response-check block and its checker.
package sdrc_pkg;

   typedef enum logic [1:0] {
      SDRC_IDLE,
      SDRC_WAIT_RESP,
      SDRC_WAIT_BUSY,
      SDRC_XFER
   } sdrc_state_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] index;
      logic [1:0] fmt;
      logic       long_resp;
      logic       short_resp;
      logic       busy_wait;
   } sdrc_issue_t;

   typedef struct packed {
      logic       valid;
      logic       auto_stop;
      logic [5:0] index;
      logic       crc_ok;
   } sdrc_resp_t;

   typedef struct packed {
      logic active;
      logic dir;
      logic dma;
      logic multi;
   } sdrc_xfer_t;

endpackage

// File: rtl/sdrc_resp_check.sv
// Index and CRC7 checks applied to one received command response.
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_regs.svh"

module sdrc_resp_check import sdrc_pkg::*; (
   // Response and its context
   input  wire sdrc_resp_t resp,
   input  wire logic       fire,
   input  wire logic [1:0] fmt,
   input  wire logic       response_index_check_enable,
   input  wire logic       response_crc_check_enable,
   input  wire logic [5:0] issued_index,
   // Verdicts
   output logic            idx_err,
   output logic            crc_err
);

   logic       expect_resp;
   logic [5:0] want_index;

   // An automatic stop always expects a response and ignores the enables.
   assign expect_resp = resp.auto_stop | (fmt != `SDRC_FMT_NONE);
   assign want_index  = resp.auto_stop ? `SDRC_AUTO_IDX : issued_index;
   assign idx_err = fire & expect_resp & (resp.auto_stop | response_index_check_enable)
                  & (resp.index != want_index);
   assign crc_err = fire & expect_resp & (resp.auto_stop | response_crc_check_enable)
                  & ~resp.crc_ok;

endmodule
`default_nettype wire

// File: rtl/sdrc_top.sv
// Command and transfer-mode register bank with response checks.
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_regs.svh"

// How it works
// - Index comparison happens only while the index-check enable bit is set, except for automatic stop responses.
// - Index mismatch under enabled checking sets status bit 19.
// - Automatic stop responses are always index checked.
// - CRC7 verification happens only while the CRC-check enable bit is set, except for automatic stop responses.
// - CRC7 mismatch under enabled checking sets status bit 17.
// - Automatic stop responses always have their CRC verified.
// - Format 0 none, 1 long 136-bit, 2 short 48-bit response.
// - Format 3 waits for a 48-bit response then the card's busy.
// - With multi-block select clear, one block ends the transfer.
// - Multi-block with block count gate clear runs without end.
// - Direction bit 0 writes to the card, 1 reads from it.
// - Multi-block with gate set ends after the programmed block count.
module sdrc_top import sdrc_pkg::*; (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Card-side engines
   input  wire sdrc_resp_t  resp_i,
   input  wire logic        card_busy,
   input  wire logic        block_done,
   input  wire logic        xfer_abort,
   output sdrc_issue_t      issue_o,
   output sdrc_xfer_t       xfer_o,
   // Interrupt
   output logic             irq
);

   localparam logic [31:0] CMD_WM = `SDRC_CMD_WMASK;
   localparam logic [31:0] BLK_WM = `SDRC_BLK_WMASK;
   localparam logic [31:0] STAT_WM = `SDRC_STAT_MASK;

   logic [31:0]  cmd_q;
   logic [31:0]  blk_q;
   logic [31:0]  stat_q;
   logic [31:0]  mask_q;
   logic [31:0]  rdata_q;
   logic [31:0]  set_vec;
   logic [31:0]  rd_mux;
   logic [15:0]  left_q;
   logic [15:0]  done_q;
   sdrc_state_t  state_q;
   sdrc_state_t  state_d;
   sdrc_issue_t  issue_q;
   logic         ack_q;
   logic         go_q;
   logic         irq_q;
   logic         wr_ok;
   logic         rd_ok;
   logic         launch;
   logic         resp_fire;
   logic         idx_err;
   logic         crc_err;
   logic         cmd_done;
   logic         xfer_done;
   logic         last_blk;
   logic         st_idle;
   logic         st_xfer;
   logic [1:0]   fmt;
   logic [5:0]   cmd_index;
   logic         response_index_check_enable;
   logic         response_crc_check_enable;
   logic         dp;
   logic         multi_block_select;
   logic         bce;

   assign fmt       = cmd_q[`SDRC_B_FMT_LO +: 2];
   assign cmd_index = cmd_q[`SDRC_B_IDX_LO +: 6];
   assign response_index_check_enable      = cmd_q[`SDRC_B_RESPONSE_INDEX_CHECK_ENABLE];
   assign response_crc_check_enable      = cmd_q[`SDRC_B_RESPONSE_CRC_CHECK_ENABLE];
   assign dp        = cmd_q[`SDRC_B_DP];
   assign multi_block_select      = cmd_q[`SDRC_B_MULTI_BLOCK_SELECT];
   assign bce       = cmd_q[`SDRC_B_BCE];
   assign st_idle   = (state_q == SDRC_IDLE);
   assign st_xfer   = (state_q == SDRC_XFER);

   // ======================================================================
   // Bus slave
   // Every access costs one wait cycle; read data is captured in it.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata    = rdata_q;
   assign wr_ok           = avs_write & ack_q;
   assign rd_ok           = avs_read & ack_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   always_comb begin
      case (avs_address)
         `SDRC_OFS_CMD:  rd_mux = cmd_q;
         `SDRC_OFS_BLK:  rd_mux = blk_q;
         `SDRC_OFS_STAT: rd_mux = stat_q;
         `SDRC_OFS_MASK: rd_mux = mask_q;
         `SDRC_OFS_PROG: rd_mux = {done_q, 14'h0000, state_q};
         default:        rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read && !ack_q) begin
         rdata_q <= rd_mux;
      end
   end

   // ======================================================================
   // Command and transfer-mode register
   // The mode byte is frozen during a transfer; the command bytes are
   // frozen until the block is idle, so checks never change mid-command.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= `SDRC_CMD_RST;
      end else if (wr_ok && avs_address == `SDRC_OFS_CMD) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i] && (i == 0 ? !st_xfer : st_idle)) begin
               cmd_q[8*i +: 8] <= avs_writedata[8*i +: 8]
                                & CMD_WM[8*i +: 8];
            end
         end
      end
   end

   // A write into the top byte sends the command from the idle state.
   assign launch = wr_ok && (avs_address == `SDRC_OFS_CMD)
                 && avs_byteenable[3] && st_idle;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         go_q <= 1'b0;
      end else begin
         go_q <= launch;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blk_q <= `SDRC_BLK_RST;
      end else if (wr_ok && avs_address == `SDRC_OFS_BLK && !st_xfer) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
               blk_q[8*i +: 8] <= avs_writedata[8*i +: 8] & BLK_WM[8*i +: 8];
            end
         end
      end
   end

   // ======================================================================
   // Response checks
   assign resp_fire = resp_i.valid
                    & ((state_q == SDRC_WAIT_RESP) | resp_i.auto_stop);

   sdrc_resp_check u_check (
      .resp         (resp_i),
      .fire         (resp_fire),
      .fmt          (fmt),
      .response_index_check_enable         (response_index_check_enable),
      .response_crc_check_enable         (response_crc_check_enable),
      .issued_index (cmd_index),
      .idx_err      (idx_err),
      .crc_err      (crc_err)
   );

   // ======================================================================
   // Command and transfer sequencing
   assign last_blk = !multi_block_select || (bce && left_q <= 16'h0001);

   always_comb begin
      state_d   = state_q;
      cmd_done  = 1'b0;
      xfer_done = 1'b0;
      case (state_q)
         SDRC_IDLE: begin
            if (go_q && fmt == `SDRC_FMT_NONE) begin
               cmd_done = 1'b1;
               state_d  = dp ? SDRC_XFER : SDRC_IDLE;
            end else if (go_q) begin
               state_d = SDRC_WAIT_RESP;
            end
         end
         SDRC_WAIT_RESP: begin
            if (resp_fire && !resp_i.auto_stop) begin
               if (fmt == `SDRC_FMT_48B) begin
                  state_d = SDRC_WAIT_BUSY;
               end else begin
                  cmd_done = 1'b1;
                  state_d  = (dp && !idx_err && !crc_err) ? SDRC_XFER
                                                         : SDRC_IDLE;
               end
            end
         end
         SDRC_WAIT_BUSY: begin
            // The card must raise busy by the cycle after its response.
            if (!card_busy) begin
               cmd_done = 1'b1;
               state_d  = dp ? SDRC_XFER : SDRC_IDLE;
            end
         end
         SDRC_XFER: begin
            if (xfer_abort || (block_done && last_blk)) begin
               xfer_done = 1'b1;
               state_d   = SDRC_IDLE;
            end
         end
         default: state_d = SDRC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SDRC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Blocks left counts down only when the count gate is on.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         left_q <= 16'h0000;
         done_q <= 16'h0000;
      end else if (go_q) begin
         left_q <= blk_q[`SDRC_B_CNT_LO +: 16];
         done_q <= 16'h0000;
      end else if (st_xfer && block_done) begin
         done_q <= done_q + 16'h0001;
         if (multi_block_select && bce) begin
            left_q <= left_q - 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         issue_q <= '0;
      end else begin
         issue_q.valid      <= go_q && st_idle;
         issue_q.index      <= cmd_index;
         issue_q.fmt        <= fmt;
         issue_q.long_resp  <= (fmt == `SDRC_FMT_136);
         issue_q.short_resp <= fmt[1];
         issue_q.busy_wait  <= (fmt == `SDRC_FMT_48B);
      end
   end

   assign issue_o      = issue_q;
   assign xfer_o.active = st_xfer;
   assign xfer_o.dir    = cmd_q[`SDRC_B_TRANSFER_DIRECTION];
   assign xfer_o.dma    = cmd_q[`SDRC_B_DE];
   assign xfer_o.multi  = multi_block_select;

   // ======================================================================
   // Status, mask and interrupt
   // A status read clears the bits; an event in the same cycle survives.
   always_comb begin
      set_vec = 32'h00000000;
      set_vec[`SDRC_S_CDONE] = cmd_done;
      set_vec[`SDRC_S_XDONE] = xfer_done;
      set_vec[`SDRC_S_CRC]   = crc_err;
      set_vec[`SDRC_S_IDX]   = idx_err;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stat_q <= 32'h00000000;
      end else if (rd_ok && avs_address == `SDRC_OFS_STAT) begin
         stat_q <= set_vec;
      end else begin
         stat_q <= stat_q | set_vec;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= 32'h00000000;
      end else if (wr_ok && avs_address == `SDRC_OFS_MASK) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_byteenable[i]) begin
               mask_q[8*i +: 8] <= avs_writedata[8*i +: 8]
                                 & STAT_WM[8*i +: 8];
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign irq = irq_q;

   // ======================================================================
   // Checks
   AST_IDX_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && !resp_i.auto_stop && !response_index_check_enable |=> !stat_q[`SDRC_S_IDX]
         || $past(stat_q[`SDRC_S_IDX]))
      else $error("index error raised while index check is off");

   AST_IDX_SET: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && !resp_i.auto_stop && response_index_check_enable && fmt != `SDRC_FMT_NONE
         && resp_i.index != cmd_index |=> stat_q[`SDRC_S_IDX])
      else $error("index mismatch not flagged");

   AST_AUTO_IDX: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && resp_i.auto_stop && resp_i.index != `SDRC_AUTO_IDX
         |=> stat_q[`SDRC_S_IDX])
      else $error("automatic stop index mismatch not flagged");

   AST_CRC_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && !resp_i.auto_stop && !response_crc_check_enable |-> !crc_err)
      else $error("crc error raised while crc check is off");

   AST_CRC_SET: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && response_crc_check_enable && fmt != `SDRC_FMT_NONE && !resp_i.crc_ok
         |=> stat_q[`SDRC_S_CRC])
      else $error("crc mismatch not flagged");

   AST_AUTO_CRC: assert property (@(posedge mclk) disable iff (!rst_n)
      resp_fire && resp_i.auto_stop && !resp_i.crc_ok |-> crc_err)
      else $error("automatic stop crc mismatch not flagged");

   AST_FMT: assert property (@(posedge mclk) disable iff (!rst_n)
      issue_o.valid |-> issue_o.long_resp == (issue_o.fmt == `SDRC_FMT_136)
         && issue_o.short_resp == issue_o.fmt[1])
      else $error("issued length does not match the format");

   AST_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
      state_q == SDRC_WAIT_BUSY && card_busy |=> state_q == SDRC_WAIT_BUSY
         && !stat_q[`SDRC_S_CDONE] || $past(stat_q[`SDRC_S_CDONE]))
      else $error("command completed while card still busy");

   AST_SINGLE: assert property (@(posedge mclk) disable iff (!rst_n)
      st_xfer && !multi_block_select && block_done |=> st_idle && stat_q[`SDRC_S_XDONE])
      else $error("single block transfer did not end after one block");

   AST_INF: assert property (@(posedge mclk) disable iff (!rst_n)
      st_xfer && multi_block_select && !bce && !xfer_abort |=> st_xfer)
      else $error("ungated multi-block transfer stopped");

   AST_COUNT: assert property (@(posedge mclk) disable iff (!rst_n)
      st_xfer && multi_block_select && bce && block_done && left_q > 16'h0001
         && !xfer_abort |=> st_xfer && left_q == $past(left_q) - 16'h0001)
      else $error("gated block count not followed");

   AST_NORESP: assert property (@(posedge mclk) disable iff (!rst_n)
      st_idle && go_q && fmt == `SDRC_FMT_NONE
         |=> state_q != SDRC_WAIT_RESP)
      else $error("response awaited with no response expected");

   AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmd_q & ~CMD_WM) == 32'h00000000)
      else $error("reserved command bits not zero");

endmodule
`default_nettype wire

// File: bench/sdrc_card_model.sv
// Behavioural card that answers issued commands and holds busy.
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Card model
module sdrc_card_model import sdrc_pkg::*; (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Host side
   input  wire sdrc_issue_t issue_o,
   output sdrc_resp_t       resp_i,
   output logic             card_busy,
   // Fault and automatic stop controls
   input  wire logic        bad_idx,
   input  wire logic        bad_crc,
   input  wire logic        auto_go
);
   logic [2:0] dly_q;
   logic [5:0] idx_q;
   logic       bw_q;
   logic [4:0] busy_q;

   // Idle response lines toggle so that a stale value never looks valid.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         resp_i <= '0;
         dly_q  <= 3'h0;
         idx_q  <= 6'h00;
         bw_q   <= 1'h0;
         busy_q <= 5'h00;
      end else begin
         resp_i.valid     <= 1'h0;
         resp_i.auto_stop <= 1'h0;
         resp_i.index     <= ~resp_i.index;
         resp_i.crc_ok    <= ~resp_i.crc_ok;
         if (issue_o.valid && issue_o.fmt != 2'h0) begin
            idx_q <= issue_o.index;
            bw_q  <= issue_o.busy_wait;
            dly_q <= 3'h2;
         end else if (dly_q != 3'h0) begin
            dly_q <= dly_q - 3'h1;
         end
         if (dly_q == 3'h1 || auto_go) begin
            resp_i.valid     <= 1'h1;
            resp_i.auto_stop <= auto_go;
            resp_i.index     <= (auto_go ? 6'h0C : idx_q) ^ {5'h00, bad_idx};
            resp_i.crc_ok    <= !bad_crc;
            busy_q <= (bw_q && !auto_go) ? 5'h14 : 5'h00;
         end else if (busy_q != 5'h00) begin
            busy_q <= busy_q - 5'h01;
         end
      end
   end

   assign card_busy = busy_q != 5'h00;
endmodule
`default_nettype wire

// File: bench/sdrc_top_bench.sv
// Self-checking bench for the response-check register bank.
`timescale 1ns/1ps
`default_nettype none
`include "sdrc_regs.svh"

module sdrc_top_bench import sdrc_pkg::*; ;
   logic        mclk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'h0;
   logic        avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   sdrc_resp_t  resp_i;
   logic        card_busy;
   logic        block_done = 1'h0;
   logic        xfer_abort = 1'h0;
   sdrc_issue_t issue_o;
   sdrc_issue_t last_iss;
   sdrc_xfer_t  xfer_o;
   logic        irq;
   logic        bad_idx = 1'h0;
   logic        bad_crc = 1'h0;
   logic        auto_go = 1'h0;
   logic [31:0] q;
   int          miscompares = 0;
   int          n_compared = 0;

   always #5 mclk = ~mclk;

   always_ff @(posedge mclk) begin
      if (issue_o.valid === 1'h1) begin
         last_iss <= issue_o;
      end
   end

   sdrc_top u_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .resp_i(resp_i), .card_busy(card_busy), .block_done(block_done),
      .xfer_abort(xfer_abort), .issue_o(issue_o), .xfer_o(xfer_o),
      .irq(irq));

   sdrc_card_model u_card (.mclk(mclk), .rst_n(rst_n), .issue_o(issue_o),
      .resp_i(resp_i), .card_busy(card_busy), .bad_idx(bad_idx),
      .bad_crc(bad_crc), .auto_go(auto_go));

   // ======================================================================
   // Shared tasks
   task automatic end_sim;
      $display("compared %0d, mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A hung wait is scored as a mismatch and closes the run.
   task automatic tmo;
      chk(32'h00000001, 32'h00000000);
      end_sim();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rq);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address    <= a;
      avs_write      <= wr;
      avs_read       <= !wr;
      avs_writedata  <= d;
      avs_byteenable <= be;
      do begin
         @(negedge mclk);
         n++;
      end while (avs_waitrequest !== 1'h0 && n < 20);
      if (avs_waitrequest !== 1'h0) tmo();
      // The edge that samples waitrequest low is the one that takes data.
      @(posedge mclk);
      rq = avs_readdata;
      avs_write <= 1'h0;
      avs_read  <= 1'h0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] r;
      bus(1'h0, a, 32'h00000000, 4'hF, r);
      chk(r & m, e);
   endtask

   task automatic launch(input logic [5:0] ix, input logic [1:0] f,
                         input logic dp, ci, cc, ms, dd, bc);
      bus(1'h1, `SDRC_OFS_CMD, {2'h0, ix, 2'h0, dp, ci, cc, 1'h0, f,
          10'h000, ms, dd, 2'h0, bc, 1'h0}, 4'hF, q);
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         bus(1'h0, `SDRC_OFS_PROG, 32'h00000000, 4'hF, q);
         n++;
      end while (q[1:0] !== 2'h0 && n < 40);
      if (q[1:0] !== 2'h0) tmo();
   endtask

   // Selects 0 block done, 1 abort, 2 automatic stop response.
   task automatic pulse(input int s);
      @(posedge mclk);
      block_done <= (s == 0);
      xfer_abort <= (s == 1);
      auto_go    <= (s == 2);
      @(posedge mclk);
      block_done <= 1'h0;
      xfer_abort <= 1'h0;
      auto_go    <= 1'h0;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_regs;
      for (int a = 0; a < 6; a++) rdc(8'(a * 4), 32'hFFFFFFFF, 32'h0);
      bus(1'h1, 8'h20, 32'hFFFFFFFF, 4'hF, q);
      rdc(8'h20, 32'hFFFFFFFF, 32'h00000000);
      bus(1'h1, `SDRC_OFS_CMD, 32'hFFFFFFFF, 4'h7, q);
      rdc(`SDRC_OFS_CMD, 32'hFFFFFFFF, 32'h00FB0033);
      bus(1'h1, `SDRC_OFS_CMD, 32'h00000000, 4'h7, q);
      $display("test regs done");
   endtask

   task automatic t_checks;
      logic [31:0] e;
      bus(1'h1, `SDRC_OFS_MASK, 32'h000A0000, 4'hF, q);
      bad_idx <= 1'h1;
      bad_crc <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         launch(6'h11, i[2] ? 2'h2 : 2'h0, 1'h0, i[0], i[1], 1'h0, 1'h0, 1'h0);
         cyc(3);
         wait_idle();
         cyc(2);
         e = {12'h000, i[0] & i[2], 1'h0, i[1] & i[2], 17'h00000};
         chk({31'h0, irq}, {31'h0, |e});
         rdc(`SDRC_OFS_STAT, 32'h000A0000, e);
         cyc(2);
         chk({31'h0, irq}, 32'h00000000);
      end
      $display("test checks done");
   endtask

   task automatic t_fmt;
      bad_idx <= 1'h0;
      bad_crc <= 1'h0;
      for (int f = 0; f < 4; f++) begin
         launch(6'h07, f[1:0], 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
         cyc(10);
         if (f == 3) rdc(`SDRC_OFS_PROG, 32'h00000003, 32'h00000002);
         wait_idle();
         chk({21'h0, last_iss.index, last_iss.fmt, last_iss.long_resp,
              last_iss.short_resp, last_iss.busy_wait},
             {21'h0, 6'h07, f[1:0], f == 1, f >= 2, f == 3});
         rdc(`SDRC_OFS_STAT, 32'h000A0001, 32'h00000001);
      end
      $display("test formats done");
   endtask

   task automatic t_auto;
      bus(1'h1, `SDRC_OFS_CMD, 32'h00000000, 4'h7, q);
      for (int k = 0; k < 2; k++) begin
         bad_idx <= (k == 0);
         bad_crc <= (k == 0);
         pulse(2);
         cyc(3);
         rdc(`SDRC_OFS_STAT, 32'h000A0000, k ? 32'h0 : 32'h000A0000);
      end
      $display("test auto stop done");
   endtask

   task automatic t_xfer;
      logic [2:0] m;
      int         endk;
      int         n;
      bus(1'h1, `SDRC_OFS_BLK, 32'h00030200, 4'hF, q);
      rdc(`SDRC_OFS_BLK, 32'hFFFFFFFF, 32'h00030200);
      for (int c = 0; c < 3; c++) begin
         m    = (c == 0) ? 3'h3 : (c == 1) ? 3'h6 : 3'h5;
         endk = (c == 0) ? 1 : (c == 1) ? 3 : 9;
         launch(6'h12, 2'h2, 1'h1, 1'h0, 1'h0, m[2], m[0], m[1]);
         n = 0;
         do begin
            @(negedge mclk);
            n++;
         end while (xfer_o.active !== 1'h1 && n < 40);
         if (xfer_o.active !== 1'h1) tmo();
         chk({29'h0, xfer_o.active, xfer_o.dir, xfer_o.multi},
             {29'h0, 1'h1, m[0], m[2]});
         for (int k = 1; k < 5; k++) begin
            pulse(0);
            cyc(2);
            @(negedge mclk);
            chk({31'h0, xfer_o.active}, {31'h0, k < endk});
         end
         if (endk > 4) pulse(1);
         cyc(2);
         rdc(`SDRC_OFS_STAT, 32'h00000002, 32'h00000002);
         rdc(`SDRC_OFS_PROG, 32'hFFFF0000,
             {16'((endk > 4) ? 4 : endk), 16'h0000});
      end
      $display("test transfers done");
   endtask

   initial begin
      cyc(4);
      rst_n <= 1'h1;
      t_regs();
      t_checks();
      t_fmt();
      t_auto();
      t_xfer();
      end_sim();
   end
endmodule
`default_nettype wire
